// ### rtl/vseq_ctl_regs.vh
`ifndef VSEQ_CTL_REGS_VH
`define VSEQ_CTL_REGS_VH
// Register byte addresses on the APB slave
`define REG_REP_B_ODD 8'h00
`define REG_REP_C_ODD 8'h04
`define REG_REP_D_ODD 8'h08
`define REG_REP_B_EVEN 8'h0C
`define REG_REP_C_EVEN 8'h10
`define REG_REP_D_EVEN 8'h14
`define REG_HOLD_A 8'h18
`define REG_HOLD_B 8'h1C
`define REG_HOLD_C 8'h20
`define REG_HOLD_D 8'h24
`define REG_CONT_A 8'h28
`define REG_CONT_B 8'h2C
`define REG_CONT_C 8'h30
`define REG_CONT_D 8'h34
`define REG_FINAL_A 8'h38
`define REG_FINAL_B 8'h3C
`define REG_FINAL_C 8'h40
`define REG_FINAL_D 8'h44
`define REG_CTRL 8'h48
`define REG_LEN_A 8'h4C
`define REG_REP_A 8'h50
`define REG_MASK 8'h54
`define REG_STATUS 8'h58
// Control register fields
`define CTRL_SEG_EN 0
`define CTRL_ADV 1
`define CTRL_RET 2
`define CTRL_INS_LO 4
`define CTRL_INS_HI 6
`define CTRL_FLE_LO 8
`define CTRL_FLE_HI 11
// Widths and reset values
`define POS_W 13
`define SEG_W 18
`define SEG_HI_W 5
`define RST_POS 13'h0000
`define RST_LEN 13'h0001
`define NUM_HOLD 4
`endif

// ### rtl/pos_match.v
// Compares the pixel counter against one programmed position
module pos_match (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Pixel counter and position
    input wire [12:0] pixel_in,
    input wire [12:0] pos_in,
    input wire enable_in,
    // Registered one-cycle hit
    output reg hit_out
);
    // Registered so the compare does not lengthen the hold path
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hit_out <= 1'b0;
        end else begin
            hit_out <= enable_in && (pixel_in == pos_in);
        end
    end
endmodule // pos_match

// ### rtl/seg_pick.v
// Picks the group code of one segment from two select words
module seg_pick (
    // Select words
    input wire [17:0] sel0_in,
    input wire [17:0] sel1_in,
    // Segment index
    input wire [4:0] index_in,
    // Group code: 0 A, 1 B, 2 C, 3 D
    output wire [1:0] group_out
);
    // Index above 17 falls back to group A
    wire in_range;
    assign in_range = (index_in < 5'd18);
    assign group_out = in_range ?
        {sel0_in[index_in], sel1_in[index_in]} : 2'b00;
endmodule // seg_pick

// ### rtl/vertical_sequence_control.v
`include "vseq_ctl_regs.vh"
module vertical_sequence_control (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Timing core
    input wire [12:0] pixel_in,
    input wire line_start_in,
    input wire seq_start_in,
    input wire [4:0] region_seq_in,
    input wire seq_boundary_in,
    input wire [23:0] pattern_a_in,
    input wire [23:0] pattern_b_in,
    input wire [23:0] pattern_c_in,
    input wire [23:0] pattern_d_in,
    // Vertical outputs and state
    output reg [23:0] vout_out,
    output reg [1:0] group_out,
    output reg [12:0] length_out,
    output reg [4:0] seq_num_out,
    output reg odd_line_out
);
    // Register storage
    reg [12:0] rep_odd_r [0:2];   // Groups B, C, D odd counts
    reg [12:0] rep_even_r [0:2];  // Groups B, C, D even counts
    reg [12:0] hold_r [0:3];      // Hold positions / select low parts
    reg [12:0] cont_r [0:3];      // Continue positions / select high
    reg [12:0] final_r [0:3];     // Final lengths, A to D
    reg [12:0] len_a_r;           // Shared pattern length
    reg [12:0] rep_a_r;           // Group A count / segment count
    reg seg_en_r;
    reg adv_r;
    reg ret_r;
    reg [2:0] ins_r;
    reg [3:0] fle_r;
    reg [23:0] mask_r;            // Outputs allowed to hold
    // Sequencer state
    reg [12:0] rep_cnt_r;
    reg [12:0] len_cnt_r;
    reg [4:0] seg_idx_r;
    reg held_r;
    reg ins_done_r;
    integer i;

    // Segment select words, rebuilt from shared storage
    wire [17:0] even_sel0 = {cont_r[0][12:8], hold_r[0]};
    wire [17:0] even_sel1 = {cont_r[1][12:8], hold_r[1]};
    wire [17:0] odd_sel0 = {cont_r[2][12:8], hold_r[2]};
    wire [17:0] odd_sel1 = {cont_r[3][12:8], hold_r[3]};
    // Parity and segment index that take effect at this edge, so a
    // boundary already shows the code of the first segment
    wire odd_next = seq_start_in ? 1'b0 :
        (line_start_in ? ~odd_line_out : odd_line_out);
    wire seg_wrap = (seg_idx_r + 5'd1 >= rep_a_r[4:0]) ||
        (seg_idx_r == 5'd17);
    wire [4:0] seg_next = (seq_start_in || line_start_in || seg_wrap) ?
        5'h00 : seg_idx_r + 5'd1;
    // Parity picks the pair of select words
    wire [17:0] sel0 = odd_next ? odd_sel0 : even_sel0;
    wire [17:0] sel1 = odd_next ? odd_sel1 : even_sel1;
    wire [1:0] seg_group;

    // Bit pair of the segment about to start to group code
    seg_pick u_pick (
        .sel0_in(sel0),
        .sel1_in(sel1),
        .index_in(seg_next),
        .group_out(seg_group)
    );

    // Hold and continue position compares
    wire [3:0] hold_hit;
    wire [3:0] cont_hit;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pos
            pos_match u_hold (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .pixel_in(pixel_in),
                .pos_in(hold_r[g]),
                .enable_in(~seg_en_r),
                .hit_out(hold_hit[g])
            );
            pos_match u_cont (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .pixel_in(pixel_in),
                .pos_in(cont_r[g]),
                .enable_in(~seg_en_r),
                .hit_out(cont_hit[g])
            );
        end
    endgenerate

    // Repetition count of the current group and parity
    reg [12:0] rep_target;
    reg [1:0] cur_group;
    always @* begin
        cur_group = group_out;
        if (group_out == 2'd0) begin
            rep_target = rep_a_r;
        end else if (odd_line_out) begin
            rep_target = rep_odd_r[group_out - 2'd1];
        end else begin
            rep_target = rep_even_r[group_out - 2'd1];
        end
    end

    // Last repetition of the series
    wire last_rep = (rep_cnt_r + 13'd1 >= rep_target);
    // The repetition about to start is the last; widened so that a
    // count near the top of the range cannot wrap the compare
    wire next_last = ({1'b0, rep_cnt_r} + 14'd2 >= {1'b0, rep_target});
    wire [12:0] next_len = (next_last && fle_r[cur_group]) ?
        final_r[cur_group] : len_a_r;
    // A one-repetition A series is its own last repetition
    wire [12:0] first_len = (!seg_en_r && rep_a_r <= 13'd1 && fle_r[0]) ?
        final_r[0] : len_a_r;
    wire len_done = (len_cnt_r + 13'd1 >= length_out);
    // Insert picks the lowest enabled special group
    wire [1:0] ins_group = ins_r[0] ? 2'd1 :
        (ins_r[1] ? 2'd2 : 2'd3);

    // APB access phase decode; reads are fetched a cycle ahead of
    // pready, writes land only at the edge where pready is seen high
    wire acc_en = psel_in && penable_in && !pready_out;
    wire wr_en = psel_in && penable_in && pwrite_in && pready_out;
    wire rd_en = acc_en && !pwrite_in;
    reg [31:0] rd_mux;
    reg addr_ok;
    always @* begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b1;
        case (paddr_in)
            `REG_REP_B_ODD: rd_mux = {19'h0, rep_odd_r[0]};
            `REG_REP_C_ODD: rd_mux = {19'h0, rep_odd_r[1]};
            `REG_REP_D_ODD: rd_mux = {19'h0, rep_odd_r[2]};
            `REG_REP_B_EVEN: rd_mux = {19'h0, rep_even_r[0]};
            `REG_REP_C_EVEN: rd_mux = {19'h0, rep_even_r[1]};
            `REG_REP_D_EVEN: rd_mux = {19'h0, rep_even_r[2]};
            `REG_HOLD_A: rd_mux = {19'h0, hold_r[0]};
            `REG_HOLD_B: rd_mux = {19'h0, hold_r[1]};
            `REG_HOLD_C: rd_mux = {19'h0, hold_r[2]};
            `REG_HOLD_D: rd_mux = {19'h0, hold_r[3]};
            `REG_CONT_A: rd_mux = {19'h0, cont_r[0]};
            `REG_CONT_B: rd_mux = {19'h0, cont_r[1]};
            `REG_CONT_C: rd_mux = {19'h0, cont_r[2]};
            `REG_CONT_D: rd_mux = {19'h0, cont_r[3]};
            `REG_FINAL_A: rd_mux = {19'h0, final_r[0]};
            `REG_FINAL_B: rd_mux = {19'h0, final_r[1]};
            `REG_FINAL_C: rd_mux = {19'h0, final_r[2]};
            `REG_FINAL_D: rd_mux = {19'h0, final_r[3]};
            `REG_CTRL: rd_mux = {20'h0, fle_r, 1'b0, ins_r,
                                 1'b0, ret_r, adv_r, seg_en_r};
            `REG_LEN_A: rd_mux = {19'h0, len_a_r};
            `REG_REP_A: rd_mux = {19'h0, rep_a_r};
            `REG_MASK: rd_mux = {8'h0, mask_r};
            `REG_STATUS: rd_mux = {5'h00, seg_idx_r, held_r, odd_line_out,
                                   group_out, rep_cnt_r, seq_num_out};
            default: addr_ok = 1'b0;
        endcase
    end

    // Bus answer: one wait state, error on unmapped address
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= psel_in && penable_in && !pready_out;
            pslverr_out <= acc_en && !addr_ok;
            if (rd_en) begin
                prdata_out <= rd_mux;
            end
        end
    end

    // Register writes, taken at the edge where pready is high
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (i = 0; i < 4; i = i + 1) begin
                hold_r[i] <= `RST_POS;
                cont_r[i] <= `RST_POS;
                final_r[i] <= `RST_LEN;
            end
            for (i = 0; i < 3; i = i + 1) begin
                rep_odd_r[i] <= `RST_LEN;
                rep_even_r[i] <= `RST_LEN;
            end
            len_a_r <= `RST_LEN;
            rep_a_r <= `RST_LEN;
            seg_en_r <= 1'b0;
            adv_r <= 1'b0;
            ret_r <= 1'b0;
            ins_r <= 3'h0;
            fle_r <= 4'h0;
            mask_r <= 24'h000000;
        end else if (wr_en) begin
            case (paddr_in)
                `REG_REP_B_ODD: rep_odd_r[0] <= pwdata_in[12:0];
                `REG_REP_C_ODD: rep_odd_r[1] <= pwdata_in[12:0];
                `REG_REP_D_ODD: rep_odd_r[2] <= pwdata_in[12:0];
                `REG_REP_B_EVEN: rep_even_r[0] <= pwdata_in[12:0];
                `REG_REP_C_EVEN: rep_even_r[1] <= pwdata_in[12:0];
                `REG_REP_D_EVEN: rep_even_r[2] <= pwdata_in[12:0];
                `REG_HOLD_A: hold_r[0] <= pwdata_in[12:0];
                `REG_HOLD_B: hold_r[1] <= pwdata_in[12:0];
                `REG_HOLD_C: hold_r[2] <= pwdata_in[12:0];
                `REG_HOLD_D: hold_r[3] <= pwdata_in[12:0];
                `REG_CONT_A: cont_r[0] <= pwdata_in[12:0];
                `REG_CONT_B: cont_r[1] <= pwdata_in[12:0];
                `REG_CONT_C: cont_r[2] <= pwdata_in[12:0];
                `REG_CONT_D: cont_r[3] <= pwdata_in[12:0];
                `REG_FINAL_A: final_r[0] <= pwdata_in[12:0];
                `REG_FINAL_B: final_r[1] <= pwdata_in[12:0];
                `REG_FINAL_C: final_r[2] <= pwdata_in[12:0];
                `REG_FINAL_D: final_r[3] <= pwdata_in[12:0];
                `REG_CTRL: begin
                    seg_en_r <= pwdata_in[`CTRL_SEG_EN];
                    adv_r <= pwdata_in[`CTRL_ADV];
                    ret_r <= pwdata_in[`CTRL_RET];
                    ins_r <= pwdata_in[`CTRL_INS_HI:`CTRL_INS_LO];
                    fle_r <= pwdata_in[`CTRL_FLE_HI:`CTRL_FLE_LO];
                end
                `REG_LEN_A: len_a_r <= pwdata_in[12:0];
                `REG_REP_A: rep_a_r <= pwdata_in[12:0];
                `REG_MASK: mask_r <= pwdata_in[23:0];
                default: ;
            endcase
        end
    end

    // Pattern sequencer: length, repetition, segment and line state
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rep_cnt_r <= 13'h0000;
            len_cnt_r <= 13'h0000;
            seg_idx_r <= 5'h00;
            group_out <= 2'd0;
            length_out <= `RST_LEN;
            odd_line_out <= 1'b0;
            ins_done_r <= 1'b0;
            seq_num_out <= 5'h00;
        end else if (seq_start_in || line_start_in) begin
            // A boundary restarts the counters on the first segment
            rep_cnt_r <= 13'h0000;
            len_cnt_r <= 13'h0000;
            seg_idx_r <= 5'h00;
            ins_done_r <= 1'b0;
            group_out <= seg_en_r ? seg_group : 2'd0;
            length_out <= first_len;
            if (seq_start_in) begin
                // New sequence restarts on an even line
                odd_line_out <= 1'b0;
                seq_num_out <= region_seq_in;
            end else begin
                odd_line_out <= ~odd_line_out;
                if (ret_r) begin
                    seq_num_out <= region_seq_in;
                end else if (adv_r && !seq_boundary_in) begin
                    seq_num_out <= seq_num_out + 5'd1;
                end
            end
        end else if (len_done) begin
            len_cnt_r <= 13'h0000;
            if (seg_en_r) begin
                // Merged pattern walks the segments in order
                seg_idx_r <= seg_next;
                group_out <= seg_group;
                length_out <= len_a_r;
            end else begin
                if (!last_rep) begin
                    rep_cnt_r <= rep_cnt_r + 13'd1;
                    length_out <= next_len;
                end
                // One repetition of an A series swaps in a special group
                if (group_out == 2'd0 && ins_r != 3'h0 && !ins_done_r &&
                    !last_rep) begin
                    ins_done_r <= 1'b1;
                    group_out <= ins_group;
                end else if (ins_done_r && group_out != 2'd0) begin
                    group_out <= 2'd0;
                end
            end
        end else begin
            len_cnt_r <= len_cnt_r + 13'd1;
        end
    end

    // Hold state: set by hold position, cleared by continue
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            held_r <= 1'b0;
        end else if (seg_en_r || seq_start_in) begin
            held_r <= 1'b0;
        end else if (|hold_hit) begin
            held_r <= 1'b1;
        end else if (|cont_hit) begin
            held_r <= 1'b0;
        end
    end

    // Vertical outputs: masked bits keep their level while held
    reg [23:0] pat_sel;
    always @* begin
        case (group_out)
            2'd0: pat_sel = pattern_a_in;
            2'd1: pat_sel = pattern_b_in;
            2'd2: pat_sel = pattern_c_in;
            default: pat_sel = pattern_d_in;
        endcase
    end
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            vout_out <= 24'h000000;
        end else if (held_r) begin
            vout_out <= (vout_out & mask_r) | (pat_sel & ~mask_r);
        end else begin
            vout_out <= pat_sel;
        end
    end
endmodule // vertical_sequence_control

// ### verif/vseq_ctl_chk_sva.sv
// Watches the register port and line state of the sequencer
module vseq_ctl_chk (
    // Clock and reset
    input logic sys_clk_in,
    input logic rst_in,
    // Register port
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic [31:0] prdata_out,
    input logic pready_out,
    input logic pslverr_out,
    // Line events and state
    input logic line_start_in,
    input logic seq_start_in,
    input logic [4:0] seq_num_out,
    input logic odd_line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // One wait state: the answer follows the first access cycle
    property p_rdy_answer;
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_rdy_answer: assert property (p_rdy_answer)
        else $error("no ready after access cycle");
    // Ready is a single-cycle pulse
    property p_rdy_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready held past one cycle");
    // Ready only ever answers a pending access
    property p_rdy_cause;
        pready_out |-> $past(psel_in && penable_in);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause)
        else $error("ready without access");
    // Error flag travels only with ready
    property p_err_rdy;
        pslverr_out |-> pready_out;
    endproperty
    a_err_rdy: assert property (p_err_rdy)
        else $error("error flag without ready");
    // Read data only moves when a read is taken
    property p_rdata_hold;
        !(psel_in && penable_in && !pwrite_in && !pready_out)
            |=> $stable(prdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without read");
    // Parity flips at each line boundary that is not also a sequence start
    property p_par_toggle;
        line_start_in && !seq_start_in
            |=> odd_line_out != $past(odd_line_out);
    endproperty
    a_par_toggle: assert property (p_par_toggle)
        else $error("parity did not flip at line start");
    // A new sequence always opens on an even line
    property p_par_even;
        seq_start_in |=> !odd_line_out;
    endproperty
    a_par_even: assert property (p_par_even)
        else $error("sequence start not even");
    // Parity stays put between boundaries
    property p_par_stable;
        !line_start_in && !seq_start_in |=> $stable(odd_line_out);
    endproperty
    a_par_stable: assert property (p_par_stable)
        else $error("parity moved without boundary");
    // Sequence number moves only at line ends and sequence starts
    property p_seq_stable;
        !line_start_in && !seq_start_in |=> $stable(seq_num_out);
    endproperty
    a_seq_stable: assert property (p_seq_stable)
        else $error("sequence number moved mid-line");
endmodule // vseq_ctl_chk

// ### verif/ccd_vdrv_model.sv
// Sink model of the vertical drivers: counts output level changes
module ccd_vdrv_model (
    // Clock and observed drive levels
    input wire logic sys_clk_in,
    input wire logic [23:0] vout_in,
    input wire logic clr_in,
    // Changes seen since the last clear
    output logic [15:0] n_edges_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] last_r; // Levels seen at the previous edge
    // A frozen driver must show no change; counting proves it
    always @(posedge sys_clk_in) begin
        last_r <= vout_in;
        if (clr_in) begin
            n_edges_out <= 16'h0000;
        end else if (vout_in !== last_r) begin
            n_edges_out <= n_edges_out + 16'h0001;
        end
    end
endmodule // ccd_vdrv_model

// ### verif/tb.sv
// Register and line-level tests of the vertical sequence control
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in, rst_in, psel_in, penable_in, pwrite_in;
    logic line_start_in, seq_start_in, seq_boundary_in, clr;
    logic pready_out, pslverr_out, odd_line_out, e;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic [12:0] pixel_in, length_out;
    logic [4:0] region_seq_in, seq_num_out, s;
    logic [23:0] pattern_a_in, vout_out;
    logic [1:0] group_out;
    logic [15:0] n_edges;
    int n_fail, total_checks, cyc;
    // Each group gets a distinct, always-moving pattern
    wire [23:0] pattern_b_in = ~pattern_a_in;
    wire [23:0] pattern_c_in = {pattern_a_in[11:0], pattern_a_in[23:12]};
    wire [23:0] pattern_d_in = pattern_a_in ^ 24'h5A5A5A;

    vertical_sequence_control dut_u (.sys_clk_in, .rst_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .pixel_in, .line_start_in,
        .seq_start_in, .region_seq_in, .seq_boundary_in, .pattern_a_in,
        .pattern_b_in, .pattern_c_in, .pattern_d_in, .vout_out,
        .group_out, .length_out, .seq_num_out, .odd_line_out);
    ccd_vdrv_model drv_u (.sys_clk_in(sys_clk_in), .vout_in(vout_out),
        .clr_in(clr), .n_edges_out(n_edges));

    // 10 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    // Free-running pixel counter, patterns and hang guard
    always @(posedge sys_clk_in) begin
        pixel_in <= pixel_in + 13'h0001;
        pattern_a_in <= pattern_a_in + 24'h000001;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            $display("MISMATCH t=%0t timeout", $time);
            end_of_test;
        end
    end

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One full APB transfer; returns at an edge after release
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do @(posedge sys_clk_in); while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    // Pulse one event input, then let the outputs settle
    task automatic pulse(input bit seq);
        if (seq) seq_start_in <= 1'b1;
        else line_start_in <= 1'b1;
        @(posedge sys_clk_in);
        seq_start_in <= 1'b0;
        line_start_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask
    // Count output changes over n cycles starting at pixel p
    task automatic watch(input logic [12:0] p, input int n);
        while (pixel_in !== p) @(posedge sys_clk_in);
        clr <= 1'b1;
        @(posedge sys_clk_in);
        clr <= 1'b0;
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {psel_in, penable_in, pwrite_in, line_start_in, seq_start_in} = 0;
        {seq_boundary_in, clr, paddr_in, pwdata_in} = 0;
        {pixel_in, pattern_a_in, region_seq_in, n_fail, total_checks} = 0;
        cyc = 0;
        rst_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        // Registers keep 13 bits, upper bits read zero
        for (int i = 0; i < 18; i++) begin
            apb(1'b1, 8'(i * 4), 32'hFFFFFFFF);
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(q, 32'h00001FFF);
        end
        apb(1'b1, 8'h48, 32'hFFFFFFFF);
        apb(1'b0, 8'h48, 32'h0);
        chk(q, 32'h00000F77);
        apb(1'b1, 8'h5C, 32'hFFFFFFFF);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h5C, 32'h0);
        chk({q[30:0], e}, 32'h1);
        // Same length everywhere, 18 segments per merged pattern
        apb(1'b1, 8'h4C, 32'h00001FFF);
        apb(1'b1, 8'h50, 32'h00000012);
        apb(1'b1, 8'h54, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(8'h18 + i * 4), 32'h00000064);
            apb(1'b1, 8'(8'h28 + i * 4), 32'h000000C8);
        end
        apb(1'b1, 8'h48, 32'h0);
        $display("register test done");
        // Parity follows line boundaries, sequence start is even
        pulse(1'b1);
        chk(32'(odd_line_out), 32'h0);
        pulse(1'b0);
        chk(32'(odd_line_out), 32'h1);
        pulse(1'b0);
        chk(32'(odd_line_out), 32'h0);
        $display("parity test done");
        // Outputs freeze between hold and continue positions
        watch(13'd110, 80);
        chk(32'(n_edges), 32'h0);
        watch(13'd210, 20);
        chk(32'(n_edges != 16'h0000), 32'h1);
        // Segment mode reuses the storage, so nothing freezes
        apb(1'b1, 8'h48, 32'h00000001);
        watch(13'd110, 80);
        chk(32'(n_edges != 16'h0000), 32'h1);
        $display("hold test done");
        // Four-cycle segments: even C at slot 1, B at slot 13; odd B at 1
        apb(1'b1, 8'h4C, 32'h00000004);
        for (int i = 0; i < 8; i++)
            apb(1'b1, 8'(8'h18 + i * 4), (i == 0 || i == 3) ? 32'h2 :
                (i == 5) ? 32'h100 : 32'h0);
        pulse(1'b1);
        chk(32'(group_out), 32'h0);
        repeat (4) @(posedge sys_clk_in);
        chk(32'(group_out), 32'h2);
        repeat (48) @(posedge sys_clk_in);
        chk(32'(group_out), 32'h1);
        pulse(1'b0);
        repeat (4) @(posedge sys_clk_in);
        chk(32'(group_out), 32'h1);
        // Final length differs from the pattern length on purpose here
        apb(1'b1, 8'h50, 32'h00000003);
        apb(1'b1, 8'h38, 32'h00000002);
        apb(1'b1, 8'h48, 32'h00000100);
        pulse(1'b0);
        chk(32'(length_out), 32'h4);
        repeat (10) @(posedge sys_clk_in);
        chk(32'(length_out), 32'h2);
        // Group C replaces only the second repetition of the A series
        apb(1'b1, 8'h48, 32'h00000020);
        pulse(1'b0);
        repeat (4) @(posedge sys_clk_in);
        chk(32'(group_out), 32'h2);
        repeat (4) @(posedge sys_clk_in);
        chk(32'(group_out), 32'h0);
        $display("pattern test done");
        // Advance, boundary stop, and return to region number
        apb(1'b1, 8'h48, 32'h00000002);
        region_seq_in <= 5'h05;
        s = seq_num_out;
        pulse(1'b0);
        chk(32'(seq_num_out), 32'(5'(s + 5'h01)));
        seq_boundary_in <= 1'b1;
        s = seq_num_out;
        pulse(1'b0);
        chk(32'(seq_num_out), 32'(s));
        seq_boundary_in <= 1'b0;
        apb(1'b1, 8'h48, 32'h00000004);
        region_seq_in <= 5'h09;
        pulse(1'b0);
        chk(32'(seq_num_out), 32'h9);
        apb(1'b1, 8'h48, 32'h0);
        s = seq_num_out;
        pulse(1'b0);
        chk(32'(seq_num_out), 32'(s));
        $display("sequence test done");
        end_of_test;
    end
endmodule // tb

bind vertical_sequence_control vseq_ctl_chk chk_u (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .line_start_in(line_start_in), .seq_start_in(seq_start_in),
    .seq_num_out(seq_num_out), .odd_line_out(odd_line_out));
